// ### hdl/nvm_seq_consts.svh
// register offsets, field positions, reset values and map limits
// assumes: included by bare name from design files of the sequencer
`ifndef NVM_SEQ_CONSTS_SVH
`define NVM_SEQ_CONSTS_SVH

// ------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------
`define OFS_CTRL        8'h00
`define OFS_KEY         8'h04
`define OFS_ADDR        8'h08
`define OFS_STAT        8'h0c
`define OFS_MASK        8'h10
`define OFS_WPROT       8'h14
`define OFS_MAP         8'h18

// ------------------------------------------------------------
// flash_control_reg fields
// ------------------------------------------------------------
`define CTRL_START      0
`define CTRL_PERMIT     1
`define CTRL_PURGE      2
`define CTRL_SPACE      3
`define CTRL_LATCH      4
`define CTRL_RST        5'h00

// ------------------------------------------------------------
// status and mask fields, write-protect and address reset values
// ------------------------------------------------------------
`define STAT_DONE       0
`define STAT_PROT       1
`define STAT_RST        2'h0
`define MASK_RST        2'h0
`define WPROT_RST       15'h0000
`define ADDR_RST        15'h0000

// ------------------------------------------------------------
// unlock keys
// ------------------------------------------------------------
`define KEY_FIRST       8'h55
`define KEY_SECOND      8'haa

// ------------------------------------------------------------
// address map limits
// ------------------------------------------------------------
`define PFM_TOP         15'h3fff
`define IND_LO          16'h8000
`define IND_HI          16'hbfff
`define UID_HI          15'h0003
`define REV_ADR         15'h0005
`define DEVID_ADR       15'h0006
`define CFG_LO          15'h0007
`define CFG_HI          15'h000b
`define INFO_LO         15'h0100
`define INFO_HI         15'h02ff
`define ROW_MASK        15'h7fe0

`endif

// ### hdl/nvm_seq_pkg.sv
// types shared by the sequencer and its unlock tracker
// assumes: nothing beyond the constants header
package nvm_seq_pkg;

   typedef enum logic [1:0] {
      OP_ERASE = 2'h0,
      OP_LATCH = 2'h1,
      OP_WRITE = 2'h2
   } op_kind_t;

   typedef enum logic [1:0] {
      OPS_IDLE = 2'b01,
      OPS_RUN  = 2'b10
   } op_state_t;

   typedef enum logic [2:0] {
      UNL_IDLE = 3'b001,
      UNL_K1   = 3'b010,
      UNL_K2   = 3'b100
   } unlock_state_t;

endpackage : nvm_seq_pkg

// ### hdl/nvm_key_if.sv
// carrier between the register front end and the unlock tracker
// assumes: one clock; wr_evt marks each completed register write
`timescale 1ns/10ps
`default_nettype none
interface nvm_key_if;
   logic       wr_evt;
   logic       key_hit;
   logic       ctrl_hit;
   logic [7:0] wbyte;
   logic       start_ok;

   modport seq  (output wr_evt, output key_hit, output ctrl_hit, output wbyte,
                 input start_ok);
   modport lock (input wr_evt, input key_hit, input ctrl_hit, input wbyte,
                 output start_ok);
endinterface : nvm_key_if
`default_nettype wire

// ### hdl/nvm_unlock_tracker.sv
// unlock tracker: watches the stream of register writes for the key order
// assumes: every register write shows as one wr_evt cycle, in bus order
`timescale 1ns/10ps
`default_nettype none
`include "nvm_seq_consts.svh"
module nvm_unlock_tracker
   import nvm_seq_pkg::*;
(
   // clock and reset
   input  wire logic aclk,
   input  wire logic aresetn,
   // write stream
   nvm_key_if.lock   lk
);
   unlock_state_t st_r;
   unlock_state_t st_nxt;
   logic          ok_r;
   logic          ok_nxt;

   wire is_k1  = lk.key_hit && (lk.wbyte == `KEY_FIRST);
   wire is_k2  = lk.key_hit && (lk.wbyte == `KEY_SECOND);
   wire is_go  = lk.ctrl_hit && lk.wbyte[`CTRL_START];

   // any write off the exact order drops back; a fresh first key restarts
   always_comb
   begin
      st_nxt = st_r;
      ok_nxt = 1'b0;
      if (lk.wr_evt)
      begin
         unique case (st_r)
            UNL_IDLE: st_nxt = is_k1 ? UNL_K1 : UNL_IDLE;
            UNL_K1:   st_nxt = is_k2 ? UNL_K2 : (is_k1 ? UNL_K1 : UNL_IDLE);
            UNL_K2:
            begin
               ok_nxt = is_go;
               st_nxt = is_k1 ? UNL_K1 : UNL_IDLE;
            end
            default: st_nxt = UNL_IDLE;
         endcase
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         st_r <= UNL_IDLE;
         ok_r <= 1'b0;
      end
      else
      begin
         st_r <= st_nxt;
         ok_r <= ok_nxt;
      end
   end

   assign lk.start_ok = ok_r;

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   a_go_after_keys: assert property (lk.start_ok |-> $past(st_r == UNL_K2 && lk.wr_evt
                                     && is_go))
      else $error("start accepted without both keys in order");
   a_break_resets: assert property (st_r == UNL_K1 && lk.wr_evt && !is_k1 && !is_k2
                                    |=> st_r == UNL_IDLE && !lk.start_ok)
      else $error("broken key order did not reset tracker");
endmodule : nvm_unlock_tracker
`default_nettype wire

// ### hdl/nvm_unlock_erase_sequencer.sv
// flash self-programming sequencer with AXI4-Lite register access
// assumes: flash array answers each op request with one done pulse
//
// Design decisions made here: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none
`include "nvm_seq_consts.svh"
// Overview of operation
// - keys 55h then AAh, then start
// - erase, latch, write need completed unlock
// - key steps back to back, else fail
// - stall CPU until operation completes
// - next instruction runs without padding
// - whole-row erase only, no auto erase
// - space select picks flash or user ID
// - purge plus permit selects erase
// - protected row: clear start, skip erase
// - done flag set, interrupt if masked in
// - erase keeps latches and permit bit
// - space 0: flash rw, indirect read-only
// - space 1: user ID rw, device ID, info area read-only
// - broken unlock starts nothing
module nvm_unlock_erase_sequencer
   import nvm_seq_pkg::*;
(
   // clock and reset
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // axi4-lite write address and data
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   // axi4-lite write response
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   // axi4-lite read
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // flash array side
   output logic             flash_op_req,
   output logic [1:0]       flash_op_kind,
   output logic             flash_op_space,
   output logic [14:0]      flash_op_addr,
   input  wire logic        flash_op_done,
   // core side
   output logic             cpu_stall,
   output logic             irq
);
   // ------------------------------------------------------------
   // address map decode
   // ------------------------------------------------------------
   function automatic logic map_ok(input logic sp, input logic [14:0] a, input logic wr);
      logic rw;
      logic ro;
      rw = sp ? (a <= `UID_HI || (a >= `CFG_LO && a <= `CFG_HI)) : (a <= `PFM_TOP);
      ro = sp && (a == `REV_ADR || a == `DEVID_ADR || (a >= `INFO_LO && a <= `INFO_HI));
      return rw || (ro && !wr);
   endfunction : map_ok

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   logic [4:0]  ctrl_r;
   logic [14:0] addr_r;
   logic [1:0]  stat_r;
   logic [1:0]  stat_nxt;
   logic [1:0]  mask_r;
   logic [14:0] wprot_r;
   op_state_t   st_r;

   logic        aw_hold_r;
   logic        w_hold_r;
   logic [7:0]  aw_addr_r;
   logic [31:0] w_data_r;
   logic [3:0]  w_strb_r;

   nvm_key_if   lk ();

   // ------------------------------------------------------------
   // write channel
   // ------------------------------------------------------------
   wire aw_take   = s_axi_awvalid && s_axi_awready;
   wire w_take    = s_axi_wvalid && s_axi_wready;
   wire do_write  = aw_hold_r && w_hold_r && !s_axi_bvalid;
   wire lane0     = w_strb_r[0];
   wire wr_ctrl   = do_write && aw_addr_r == `OFS_CTRL && lane0;
   wire wr_key    = do_write && aw_addr_r == `OFS_KEY && lane0;
   wire wr_addr   = do_write && aw_addr_r == `OFS_ADDR;
   wire wr_mask   = do_write && aw_addr_r == `OFS_MASK && lane0;
   wire wr_wprot  = do_write && aw_addr_r == `OFS_WPROT;
   wire wr_known  = aw_addr_r == `OFS_CTRL || aw_addr_r == `OFS_KEY ||
                    aw_addr_r == `OFS_ADDR || aw_addr_r == `OFS_MASK ||
                    aw_addr_r == `OFS_WPROT || aw_addr_r == `OFS_STAT ||
                    aw_addr_r == `OFS_MAP;
   wire aw_hold_nxt = (aw_hold_r || aw_take) && !do_write;
   wire w_hold_nxt  = (w_hold_r || w_take) && !do_write;
   wire bvalid_nxt  = do_write || (s_axi_bvalid && !s_axi_bready);

   // every register write is fed to the tracker so a stray one breaks the order
   assign lk.wr_evt   = do_write;
   assign lk.key_hit  = wr_key;
   assign lk.ctrl_hit = wr_ctrl;
   assign lk.wbyte    = w_data_r[7:0];

   nvm_unlock_tracker u_lock (
      .aclk    (aclk),
      .aresetn (aresetn),
      .lk      (lk.lock)
   );

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_hold_r     <= 1'b0;
         w_hold_r      <= 1'b0;
         aw_addr_r     <= 8'h00;
         w_data_r      <= 32'h0000_0000;
         w_strb_r      <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= 2'h0;
      end
      else
      begin
         aw_hold_r     <= aw_hold_nxt;
         w_hold_r      <= w_hold_nxt;
         s_axi_awready <= !aw_hold_nxt;
         s_axi_wready  <= !w_hold_nxt;
         s_axi_bvalid  <= bvalid_nxt;
         if (aw_take)
            aw_addr_r <= s_axi_awaddr;
         if (w_take)
         begin
            w_data_r <= s_axi_wdata;
            w_strb_r <= s_axi_wstrb;
         end
         if (do_write)
            s_axi_bresp <= wr_known ? 2'h0 : 2'h2;
      end
   end

   // ------------------------------------------------------------
   // read channel
   // ------------------------------------------------------------
   wire        ar_take  = s_axi_arvalid && s_axi_arready;
   wire        rd_stat  = ar_take && s_axi_araddr == `OFS_STAT;
   wire        sp       = ctrl_r[`CTRL_SPACE];
   // the indirect view of a flash word sits at 8000h plus its address and is read-only
   wire        ind_ok   = !sp && {1'b1, addr_r} >= `IND_LO && {1'b1, addr_r} <= `IND_HI;
   wire [31:0] map_word = {29'h0, ind_ok, map_ok(sp, addr_r, 1'b1),
                           map_ok(sp, addr_r, 1'b0)};
   logic [31:0] rd_mux;
   logic        rd_known;

   always_comb
   begin
      rd_known = 1'b1;
      unique case (s_axi_araddr)
         `OFS_CTRL:  rd_mux = {27'h0, ctrl_r};
         `OFS_KEY:   rd_mux = 32'h0000_0000;
         `OFS_ADDR:  rd_mux = {17'h0, addr_r};
         `OFS_STAT:  rd_mux = {30'h0, stat_r};
         `OFS_MASK:  rd_mux = {30'h0, mask_r};
         `OFS_WPROT: rd_mux = {17'h0, wprot_r};
         `OFS_MAP:   rd_mux = map_word;
         default:
         begin
            rd_mux   = 32'h0000_0000;
            rd_known = 1'b0;
         end
      endcase
   end

   wire rvalid_nxt = ar_take || (s_axi_rvalid && !s_axi_rready);

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= 2'h0;
      end
      else
      begin
         s_axi_arready <= !rvalid_nxt;
         s_axi_rvalid  <= rvalid_nxt;
         if (ar_take)
         begin
            s_axi_rdata <= rd_mux;
            s_axi_rresp <= rd_known ? 2'h0 : 2'h2;
         end
      end
   end

   // ------------------------------------------------------------
   // operation control
   // ------------------------------------------------------------
   wire purge     = ctrl_r[`CTRL_PURGE];
   wire permit    = ctrl_r[`CTRL_PERMIT];
   wire row_prot  = !sp && addr_r < wprot_r;
   wire go        = lk.start_ok && st_r == OPS_IDLE && permit;
   wire target_ok = map_ok(sp, addr_r, 1'b1);
   wire refuse    = go && (row_prot || !target_ok);
   wire launch    = go && !refuse;
   wire finish    = st_r == OPS_RUN && flash_op_done;
   wire [1:0] kind_nxt = purge ? OP_ERASE :
                         (ctrl_r[`CTRL_LATCH] ? OP_LATCH : OP_WRITE);

   // a set in the same cycle as the read that clears wins
   assign stat_nxt = (stat_r & ~{2{rd_stat}}) |
                     {refuse, finish};

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         ctrl_r         <= `CTRL_RST;
         addr_r         <= `ADDR_RST;
         stat_r         <= `STAT_RST;
         mask_r         <= `MASK_RST;
         wprot_r        <= `WPROT_RST;
         st_r           <= OPS_IDLE;
         flash_op_req   <= 1'b0;
         flash_op_kind  <= 2'h0;
         flash_op_space <= 1'b0;
         flash_op_addr  <= 15'h0000;
         cpu_stall      <= 1'b0;
         irq            <= 1'b0;
      end
      else
      begin
         // software cannot set the start bit directly, only the unlock path can
         if (wr_ctrl)
            ctrl_r[4:1] <= w_data_r[4:1];
         if (wr_addr && st_r == OPS_IDLE)
            addr_r <= w_data_r[14:0];
         if (wr_mask)
            mask_r <= w_data_r[1:0];
         if (wr_wprot)
            wprot_r <= w_data_r[14:0];
         stat_r       <= stat_nxt;
         irq          <= |(stat_nxt & mask_r);
         flash_op_req <= launch;
         if (launch)
         begin
            ctrl_r[`CTRL_START] <= 1'b1;
            st_r                <= OPS_RUN;
            cpu_stall           <= 1'b1;
            flash_op_kind       <= kind_nxt;
            flash_op_space      <= sp;
            // erase goes to the row base so the array never sees a partial row
            flash_op_addr       <= purge ? (addr_r & `ROW_MASK) : addr_r;
         end
         if (refuse)
            ctrl_r[`CTRL_START] <= 1'b0;
         if (finish)
         begin
            ctrl_r[`CTRL_START] <= 1'b0;
            st_r                <= OPS_IDLE;
            // stall drops with completion; the core resumes on the next fetch
            cpu_stall           <= 1'b0;
         end
      end
   end

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   a_op_needs_unlock: assert property (flash_op_req |-> $past(lk.start_ok))
      else $error("flash op issued without unlock");
   a_permit_gate: assert property (lk.start_ok && !permit && st_r == OPS_IDLE
                                   |=> !flash_op_req && !ctrl_r[`CTRL_START])
      else $error("start honoured while permit clear");
   a_protect_skip: assert property (lk.start_ok && permit && purge && row_prot
                                    && st_r == OPS_IDLE |=> !flash_op_req
                                    && !ctrl_r[`CTRL_START] && stat_r[`STAT_PROT])
      else $error("protected row erase not skipped");
   a_stall_held: assert property (cpu_stall && !finish |=> cpu_stall)
      else $error("stall dropped before completion");
   a_resume_done: assert property (finish |=> !cpu_stall && stat_r[`STAT_DONE]
                                   && !ctrl_r[`CTRL_START])
      else $error("completion not reported");
   a_irq_masked: assert property (stat_r[`STAT_DONE] && mask_r[`STAT_DONE]
                                  && $past(mask_r[`STAT_DONE]) |-> irq)
      else $error("done interrupt missing");
   a_erase_select: assert property (flash_op_req |-> flash_op_space == $past(sp)
                                    && ((flash_op_kind == OP_ERASE) == $past(purge)))
      else $error("wrong target or op kind");
   a_row_aligned: assert property (flash_op_req && flash_op_kind == OP_ERASE
                                   |-> flash_op_addr[4:0] == 5'h00)
      else $error("erase not row aligned");
   a_map_target: assert property (flash_op_req |-> $past(target_ok))
      else $error("op on non-writable address");
   a_permit_kept: assert property (st_r == OPS_RUN && !wr_ctrl
                                   |=> $stable(ctrl_r[`CTRL_PERMIT]))
      else $error("permit bit changed by operation");
endmodule : nvm_unlock_erase_sequencer
`default_nettype wire

// ### bench/flash_array_model.sv
// flash array stand-in: answers each op request with one done pulse
// assumes: requests come as one-cycle pulses; lat sets the answer delay
`timescale 1ns/10ps
`default_nettype none
module flash_array_model
(
   // clock and reset
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // op request and answer
   input  wire logic        flash_op_req,
   input  wire logic [1:0]  flash_op_kind,
   input  wire logic [14:0] flash_op_addr,
   input  wire logic [7:0]  lat,
   output logic             flash_op_done,
   output logic             misuse
);
   logic [8:0] cnt_r;

   always_ff @(posedge aclk)
   begin
      flash_op_done <= 1'b0;
      if (!aresetn)
      begin
         cnt_r  <= 9'h000;
         misuse <= 1'b0;
      end
      else if (flash_op_req)
      begin
         cnt_r <= {1'b0, lat} + 9'h001;
         // only whole rows are erased, so the address must be a row base
         if (flash_op_kind == 2'h0 && flash_op_addr[4:0] != 5'h00)
            misuse <= 1'b1;
         // the array cannot take a second op while one runs
         if (cnt_r != 9'h000)
            misuse <= 1'b1;
      end
      else if (cnt_r != 9'h000)
      begin
         cnt_r         <= cnt_r - 9'h001;
         flash_op_done <= (cnt_r == 9'h001);
      end
   end
endmodule : flash_array_model
`default_nettype wire

// ### bench/testbench.sv
// self-checking bench for the unlock and erase sequencer
// assumes: flash_array_model answers each op request after lat+1 cycles
`timescale 1ns/10ps
`default_nettype none
`include "nvm_seq_consts.svh"
module testbench;
   logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
   logic s_axi_rready, st_seen, sd_seen;
   logic [7:0] s_axi_awaddr, s_axi_araddr, lat;
   logic [31:0] s_axi_wdata, d;
   logic [3:0] s_axi_wstrb;
   logic [1:0] r, msk, k_seen;
   logic s_seen;
   logic [14:0] a_seen, ma;
   wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   wire logic [1:0] s_axi_bresp, s_axi_rresp, flash_op_kind;
   wire logic [31:0] s_axi_rdata;
   wire logic flash_op_req, flash_op_space, flash_op_done, cpu_stall, irq, misuse;
   wire logic [14:0] flash_op_addr;
   int bad_count, check_count, seed, reqs;
   logic [14:0] tbl [12] = '{15'h0, 15'h3, 15'h4, 15'h5, 15'h6, 15'h7, 15'hb, 15'hc,
                             15'h100, 15'h2ff, 15'h3fff, 15'h4000};
   logic [7:0] ctl [4] = '{8'h06, 8'h12, 8'h02, 8'h0e};

   nvm_unlock_erase_sequencer nvm_unlock_erase_sequencer_inst (.aclk, .aresetn,
      .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .flash_op_req, .flash_op_kind, .flash_op_space,
      .flash_op_addr, .flash_op_done, .cpu_stall, .irq);
   flash_array_model flash_array_model_inst (.aclk, .aresetn, .flash_op_req,
      .flash_op_kind, .flash_op_addr, .lat, .flash_op_done, .misuse);

   initial
   begin
      aclk = 1'b0;
      forever #10 aclk = ~aclk;
   end

   // what the array was asked for, and whether the core was held meanwhile
   always @(posedge aclk)
   begin
      if (flash_op_req === 1'b1)
      begin
         reqs++;
         k_seen = flash_op_kind;
         s_seen = flash_op_space;
         a_seen = flash_op_addr;
         st_seen = cpu_stall;
      end
      if (flash_op_done === 1'b1)
         sd_seen = cpu_stall;
   end

   task automatic tally_and_finish();
      if (bad_count == 0 && check_count > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : tally_and_finish

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] m);
      check_count++;
      if ((got & m) !== (exp & m))
      begin
         bad_count++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask : chk

   // bready and rready stay high, so each wait ends on the answer edge
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      int t;
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      t = 0;
      do
      begin
         @(posedge aclk);
         t++;
         if (s_axi_awready === 1'b1)
            s_axi_awvalid <= 1'b0;
         if (s_axi_wready === 1'b1)
            s_axi_wvalid <= 1'b0;
      end
      while (s_axi_bvalid !== 1'b1 && t < 50);
      r = s_axi_bresp;
      chk(t, 0, {32{t >= 50}});
   endtask : wr

   task automatic rd(input logic [7:0] a);
      int t;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      t = 0;
      do
      begin
         @(posedge aclk);
         t++;
         if (s_axi_arready === 1'b1)
            s_axi_arvalid <= 1'b0;
      end
      while (s_axi_rvalid !== 1'b1 && t < 50);
      d = s_axi_rdata;
      r = s_axi_rresp;
      chk(t, 0, {32{t >= 50}});
   endtask : rd

   // bit 2: flash word also readable through the indirect view, space 0 only
   function automatic logic [2:0] map_exp(input logic sp, input logic [14:0] a);
      if (!sp)
         map_exp = (a <= 15'h3fff) ? 3'h7 : 3'h0;
      else if (a <= 15'h3 || (a >= 15'h7 && a <= 15'hb))
         map_exp = 3'h3;
      else if (a == 15'h5 || a == 15'h6 || (a >= 15'h100 && a <= 15'h2ff))
         map_exp = 3'h1;
      else
         map_exp = 3'h0;
   endfunction : map_exp

   // one unlock attempt; c is the control value without the start bit
   task automatic op(input logic [14:0] a, input logic [7:0] c, input logic [7:0] k1,
                     input logic [7:0] k2, input logic mid, input logic go,
                     input logic [1:0] st);
      int r0;
      int t;
      wr(`OFS_ADDR, {17'h0, a});
      wr(`OFS_CTRL, {24'h0, c});
      r0 = reqs;
      st_seen = 1'b0;
      sd_seen = 1'b0;
      wr(`OFS_KEY, {24'h0, k1});
      if (mid)
         wr(`OFS_MASK, {30'h0, msk});
      wr(`OFS_KEY, {24'h0, k2});
      wr(`OFS_CTRL, {24'h0, c | 8'h01});
      repeat (4) @(posedge aclk);
      t = 0;
      while (cpu_stall !== 1'b0 && t < 400)
      begin
         @(posedge aclk);
         t++;
      end
      chk(reqs - r0, {31'h0, go}, '1);
      if (go)
      begin
         chk({k_seen, s_seen, a_seen}, {c[2] ? 2'h0 : (c[4] ? 2'h1 : 2'h2), c[3], a}, '1);
         chk({st_seen, sd_seen}, 2'h3, 3);
      end
      rd(`OFS_CTRL);
      chk(d, c, 8'hff);
      repeat (2) @(posedge aclk);
      chk(irq, |(st & msk), 1);
      rd(`OFS_STAT);
      chk(d, st, 3);
      repeat (2) @(posedge aclk);
      chk(irq, 0, 1);
   endtask : op

   initial
   begin
      #400000;
      bad_count++;
      $display("unexpected at %0t: run did not end", $time);
      tally_and_finish();
   end

   initial
   begin
      seed = 48001;
      aresetn = 1'b0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 3'h0;
      {s_axi_bready, s_axi_rready} = 2'h3;
      s_axi_awaddr = 8'h00;
      s_axi_araddr = 8'h00;
      s_axi_wdata = 32'h0;
      s_axi_wstrb = 4'hf;
      lat = 8'h03;
      msk = 2'h1;
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      for (int i = 0; i < 7; i++)
      begin
         rd(8'(4 * i));
         chk(d, (i == 6) ? 32'h7 : 32'h0, (i == 6) ? 32'h7 : '1);
      end
      rd(8'h1c);
      chk({d[29:0], r}, 32'h2, '1);
      wr(8'h1c, '1);
      chk(r, 2, 3);
      for (int i = 0; i < 32; i++)
      begin
         ma = (i < 24) ? tbl[i / 2] : 15'($random(seed));
         wr(`OFS_ADDR, {17'h0, ma});
         chk(r, 0, 3);
         wr(`OFS_CTRL, {28'h0, i[0], 3'h0});
         rd(`OFS_MAP);
         chk(d, map_exp(i[0], ma), 7);
         chk(r, 0, 3);
      end
      wr(`OFS_MASK, 32'h1);
      for (int i = 0; i < 8; i++)
      begin
         lat <= (i == 7) ? 8'd200 : (8'($random(seed)) & 8'h0f);
         ma = (i % 4 == 3) ? 15'h0 : (15'($random(seed)) & 15'h3fe0);
         op(ma, ctl[i % 4], 8'h55, 8'haa, 1'b0, 1'b1, 2'h1);
      end
      op(15'h0040, 8'h04, 8'h55, 8'haa, 1'b0, 1'b0, 2'h0);
      op(15'h0040, 8'h06, 8'haa, 8'h55, 1'b0, 1'b0, 2'h0);
      op(15'h0040, 8'h06, 8'h55, 8'haa, 1'b1, 1'b0, 2'h0);
      op(15'h0040, 8'h06, 8'h00, 8'h00, 1'b0, 1'b0, 2'h0);
      op(15'h0005, 8'h0e, 8'h55, 8'haa, 1'b0, 1'b0, 2'h2);
      wr(`OFS_WPROT, 32'h100);
      op(15'h00e0, 8'h06, 8'h55, 8'haa, 1'b0, 1'b0, 2'h2);
      op(15'h0100, 8'h06, 8'h55, 8'haa, 1'b0, 1'b1, 2'h1);
      msk = 2'h0;
      wr(`OFS_MASK, 32'h0);
      op(15'h0200, 8'h02, 8'h55, 8'haa, 1'b0, 1'b1, 2'h1);
      chk(misuse, 0, 1);
      tally_and_finish();
   end
endmodule : testbench
`default_nettype wire
